// ### dirc_params.svh
// register map, field positions, reset values and constants of the channel
`ifndef DIRC_PARAMS_SVH
`define DIRC_PARAMS_SVH

// register byte offsets
`define DIRC_OFF_MEM_ADDR   8'h00
`define DIRC_OFF_PERI_ADDR  8'h04
`define DIRC_OFF_COUNT      8'h08
`define DIRC_OFF_CONTROL    8'h0C
`define DIRC_OFF_IRQ_STATUS 8'h10
`define DIRC_OFF_IRQ_MASK   8'h14
`define DIRC_OFF_STATE      8'h18

// control register fields
`define DIRC_CTL_ENABLE 0
`define DIRC_CTL_REPEAT 1
`define DIRC_CTL_DIR    2
`define DIRC_CTL_SIZE   3
`define DIRC_CTL_SRC_LO 4
`define DIRC_CTL_SRC_HI 6

// interrupt status fields
`define DIRC_IRQ_DONE 0
`define DIRC_IRQ_BUSERR 1

// source select codes
`define DIRC_SRC_TIMER0 3'h0
`define DIRC_SRC_TIMER3 3'h3
`define DIRC_SRC_TX_EMPTY 3'h4
`define DIRC_SRC_RX_FULL 3'h5
`define DIRC_SRC_EXT 3'h6

// reset values
`define DIRC_RST_WORD 32'h0000_0000
`define DIRC_RST_MEM 24'h00_0000
`define DIRC_RST_PERI 8'h00
`define DIRC_RST_COUNT 16'h0000
`define DIRC_RST_CTL 7'h00
`define DIRC_RST_IRQ 2'h0

// fixed values
`define DIRC_PERI_UPPER 16'hFFFF
`define DIRC_COUNT_ONE 16'h0001
`define DIRC_BYTE_ONE 8'h01
`define DIRC_BYTE_ZERO 8'h00
`define DIRC_UNIT_BYTE 24'h00_0001
`define DIRC_UNIT_WORD 24'h00_0002
`define DIRC_RESP_OKAY 2'h0
`define DIRC_RESP_SLVERR 2'h2

`endif

// ### dirc_pkg.sv
// types shared by the idle/repeat transfer channel
package dirc_pkg;

   typedef struct packed
   {
      logic [3:0] timer_match;
      logic tx_empty;
      logic rx_full;
      logic ext_req;
   } dirc_req_type;

   typedef struct packed
   {
      logic rd;
      logic wr;
      logic word;
      logic [23:0] addr;
      logic [15:0] wdata;
   } dirc_bus_req_type;

   typedef struct packed
   {
      logic done;
      logic err;
      logic [15:0] rdata;
   } dirc_bus_rsp_type;

   typedef enum logic [1:0]
   {
      dirc_idle_st = 2'b00,
      dirc_read_st = 2'b01,
      dirc_write_st = 2'b10
   } dirc_state_type;

endpackage

// ### dirc_channel.sv
// idle/repeat mode single transfer channel with axi4-lite register port
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "dirc_params.svh"

// Functional notes
// - idle or repeat mode is chosen by this channel's own control bit.
// - idle mode moves one byte or word per accepted request, count times.
// - receive-full trigger reads peripheral, writes memory; others reverse.
// - peripheral address low 8 bits, upper 16 forced ones, never stepped.
// - idle mode holds memory and peripheral addresses fixed.
// - idle mode 16-bit count drops by one after every transfer.
// - idle count reaching zero clears enable, stops, raises interrupt.
// - idle count programmed zero means 65,536 transfers.
// - requests from timers 0 to 3, serial tx/rx events, external input.
// - repeat mode: high byte runs, low byte keeps initial count.
// - repeat counter drops per transfer, reloads from initial at zero.
// - repeat address steps; reload subtracts sign*size*initial count.
// - repeat runs until enable cleared; re-enable resumes held state.
// - repeat mode never raises the completion interrupt.
// - repeat count is 8 bits, at most 256 per cycle; zero gives 256.
module dirc_channel
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // axi4-lite register port
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // transfer request sources, one-cycle pulses or levels
   input wire dirc_pkg::dirc_req_type req_in,
   // internal bus master
   output dirc_pkg::dirc_bus_req_type bus_req,
   input wire dirc_pkg::dirc_bus_rsp_type bus_rsp,
   // interrupt
   output logic irq
);
   import dirc_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [23:0] memory_address;
   logic [7:0] peripheral_address_low;
   logic [15:0] transfer_count;
   logic [6:0] channel_control;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   dirc_state_type state;
   logic [15:0] data_hold;
   logic from_peri;

   wire channel_enable = channel_control[`DIRC_CTL_ENABLE];
   wire repeat_mode = channel_control[`DIRC_CTL_REPEAT];
   wire step_direction = channel_control[`DIRC_CTL_DIR];
   wire unit_size = channel_control[`DIRC_CTL_SIZE];
   wire [2:0] src_sel = channel_control[`DIRC_CTL_SRC_HI:`DIRC_CTL_SRC_LO];
   wire [7:0] repeat_running_count = transfer_count[15:8];
   wire [7:0] repeat_initial_count = transfer_count[7:0];

   // ----------------------------------------------------------------
   // request selection
   // ----------------------------------------------------------------
   // request lines in select-code order; code 7 matches nothing
   wire [6:0] req_lines = {req_in.ext_req, req_in.rx_full, req_in.tx_empty,
      req_in.timer_match};
   wire [6:0] src_hit;
   genvar gi;
   generate
      for (gi = 0; gi <= `DIRC_SRC_EXT; gi++)
      begin : g_src
         assign src_hit[gi] = src_sel == 3'(gi) && req_lines[gi];
      end
   endgenerate
   wire req_hit = |src_hit;
   wire src_is_rx = src_sel == `DIRC_SRC_RX_FULL;
   // a level held high starts a fresh unit each time the channel is idle
   wire start_xfer = channel_enable && state == dirc_idle_st && req_hit;

   // ----------------------------------------------------------------
   // address and count arithmetic
   // ----------------------------------------------------------------
   wire [23:0] peri_full = {`DIRC_PERI_UPPER, peripheral_address_low};
   wire [23:0] unit = unit_size ? `DIRC_UNIT_WORD : `DIRC_UNIT_BYTE;
   wire [23:0] stepped = step_direction ? memory_address - unit
      : memory_address + unit;
   // span covers the whole cycle unless the initial count is zero; its sign undoes the steps taken
   wire [23:0] span = unit_size ? {15'h0000, repeat_initial_count, 1'b0}
      : {16'h0000, repeat_initial_count};
   wire [23:0] restored = step_direction ? stepped + span
      : stepped - span;
   wire [7:0] next_running = repeat_running_count - `DIRC_BYTE_ONE;
   wire wrap = next_running == `DIRC_BYTE_ZERO;
   // zero counts as 65,536 since the decrement wraps to ffff
   wire [15:0] next_count = transfer_count - `DIRC_COUNT_ONE;
   wire idle_done = next_count == `DIRC_RST_COUNT;
   // a failed write leaves counters and addresses alone
   wire xfer_done = state == dirc_write_st && bus_rsp.done && !bus_rsp.err;
   // next register values once a unit has been written
   wire [23:0] next_memory_address = wrap ? restored : stepped;
   // repeat mode runs only the high byte; the low byte is never touched
   wire [15:0] next_transfer_count = repeat_mode
      ? {wrap ? repeat_initial_count : next_running, repeat_initial_count}
      : next_count;
   wire bus_err = state != dirc_idle_st && bus_rsp.done && bus_rsp.err;

   // ----------------------------------------------------------------
   // axi4-lite decode
   // ----------------------------------------------------------------
   // address and data may arrive in either order; the early one is held
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   wire aw_ok = aw_held || (s_axi_awvalid && s_axi_awready);
   wire w_ok = w_held || (s_axi_wvalid && s_axi_wready);
   wire wr_go = aw_ok && w_ok && !s_axi_bvalid;
   wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wd = w_held ? w_data : s_axi_wdata;
   wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
   wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   wire wr_mem = wr_go && wa == `DIRC_OFF_MEM_ADDR;
   wire wr_peri = wr_go && wa == `DIRC_OFF_PERI_ADDR;
   wire wr_count = wr_go && wa == `DIRC_OFF_COUNT;
   wire wr_ctl = wr_go && wa == `DIRC_OFF_CONTROL;
   wire wr_stat = wr_go && wa == `DIRC_OFF_IRQ_STATUS;
   wire wr_mask = wr_go && wa == `DIRC_OFF_IRQ_MASK;
   wire wr_hit = wr_mem | wr_peri | wr_count | wr_ctl | wr_stat | wr_mask;
   wire [31:0] cur_mem = {8'h00, memory_address};
   wire [31:0] cur_cnt = {16'h0000, transfer_count};
   wire [31:0] new_mem = (cur_mem & ~wmask) | (wd & wmask);
   wire [31:0] new_cnt = (cur_cnt & ~wmask) | (wd & wmask);
   wire [1:0] stat_clear = wr_stat && ws[0] ? wd[1:0] : `DIRC_RST_IRQ;

   assign s_axi_arready = !s_axi_rvalid;
   wire rd_go = s_axi_arvalid && s_axi_arready;
   logic [31:0] rd_word;
   logic rd_hit;
   always_comb
   begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `DIRC_OFF_MEM_ADDR: rd_word = cur_mem;
         `DIRC_OFF_PERI_ADDR: rd_word = {24'h00_0000, peripheral_address_low};
         `DIRC_OFF_COUNT: rd_word = cur_cnt;
         `DIRC_OFF_CONTROL: rd_word = {25'h000_0000, channel_control};
         `DIRC_OFF_IRQ_STATUS: rd_word = {30'h0000_0000, irq_status};
         `DIRC_OFF_IRQ_MASK: rd_word = {30'h0000_0000, irq_mask};
         `DIRC_OFF_STATE: rd_word = {30'h0000_0000, state};
         default:
         begin
            rd_word = `DIRC_RST_WORD;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= `DIRC_OFF_MEM_ADDR;
         w_data <= `DIRC_RST_WORD;
         w_strb <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready && !wr_go)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready && !wr_go)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   // the response waits for bready; no new address or data is taken then
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DIRC_RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `DIRC_RESP_OKAY : `DIRC_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `DIRC_RST_WORD;
         s_axi_rresp <= `DIRC_RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? `DIRC_RESP_OKAY : `DIRC_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ----------------------------------------------------------------
   // transfer sequencer
   // ----------------------------------------------------------------
   logic [5:0] ctl_new;
   assign ctl_new = wd[`DIRC_CTL_SRC_HI:`DIRC_CTL_REPEAT];
   dirc_state_type next_state;

   // a bus error in either phase drops the unit and returns to idle
   always_comb
   begin
      next_state = state;
      case (state)
         dirc_idle_st:
            if (start_xfer)
               next_state = dirc_read_st;
         dirc_read_st:
            if (bus_rsp.done)
               next_state = bus_rsp.err ? dirc_idle_st : dirc_write_st;
         dirc_write_st:
            if (bus_rsp.done)
               next_state = dirc_idle_st;
         default:
            next_state = dirc_idle_st;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         state <= dirc_idle_st;
      else
         state <= next_state;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         from_peri <= 1'b0;
         data_hold <= `DIRC_RST_COUNT;
      end
      else
      begin
         if (start_xfer)
            from_peri <= src_is_rx;
         if (state == dirc_read_st && bus_rsp.done)
            data_hold <= bus_rsp.rdata;
      end
   end

   // bus request is registered-state decode, data from flip-flops
   always_comb
   begin
      bus_req.rd = state == dirc_read_st;
      bus_req.wr = state == dirc_write_st;
      bus_req.word = unit_size;
      bus_req.wdata = data_hold;
      if ((state == dirc_read_st) == from_peri)
         bus_req.addr = peri_full;
      else
         bus_req.addr = memory_address;
   end

   // ----------------------------------------------------------------
   // channel registers
   // ----------------------------------------------------------------
   // a software write wins over a hardware update in the same cycle
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         memory_address <= `DIRC_RST_MEM;
      else if (wr_mem)
         memory_address <= new_mem[23:0];
      else if (xfer_done && repeat_mode)
         memory_address <= next_memory_address;
      // idle mode leaves the memory address untouched
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         peripheral_address_low <= `DIRC_RST_PERI;
      else if (wr_peri && ws[0])
         peripheral_address_low <= wd[7:0]; // never stepped
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         transfer_count <= `DIRC_RST_COUNT;
      else if (wr_count)
         transfer_count <= new_cnt[15:0];
      else if (xfer_done)
         transfer_count <= next_transfer_count;
   end

   // hardware clear only on idle completion; repeat runs on
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         channel_control <= `DIRC_RST_CTL;
      else if (wr_ctl && ws[0])
         channel_control <= {ctl_new, wd[`DIRC_CTL_ENABLE]};
      else if (xfer_done && !repeat_mode && idle_done)
         channel_control[`DIRC_CTL_ENABLE] <= 1'b0;
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   logic [1:0] irq_set;
   assign irq_set[`DIRC_IRQ_DONE] = xfer_done && !repeat_mode
      && idle_done;
   assign irq_set[`DIRC_IRQ_BUSERR] = bus_err;

   // status bits stay set until software writes ones to them
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irq_status <= `DIRC_RST_IRQ;
      else
         // a set in the clearing cycle wins
         irq_status <= (irq_status & ~stat_clear) | irq_set;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         irq_mask <= `DIRC_RST_IRQ;
      else if (wr_mask && ws[0])
         irq_mask <= wd[1:0];
   end

   assign irq = |(irq_status & irq_mask);

endmodule

// ### dirc_monitor.sv
// assertion checker for the idle/repeat transfer channel
`timescale 1ns/1ns
module dirc_monitor
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // requests and internal bus
   input wire dirc_pkg::dirc_req_type req_in,
   input wire dirc_pkg::dirc_bus_req_type bus_req,
   input wire dirc_pkg::dirc_bus_rsp_type bus_rsp
);
   import dirc_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence read_ok;
      bus_req.rd && bus_rsp.done && !bus_rsp.err;
   endsequence
   sequence write_end;
      bus_req.wr && bus_rsp.done;
   endsequence
   a_read_holds: assert property (bus_req.rd && !bus_rsp.done
      |=> bus_req.rd && $stable(bus_req.addr)) else $error("read dropped");
   a_write_follows: assert property (read_ok |=> bus_req.wr)
      else $error("no write after read");
   a_data_passes: assert property (read_ok
      |=> bus_req.wdata == $past(bus_rsp.rdata)) else $error("data lost");
   a_peri_ones: assert property (read_ok
      |=> bus_req.addr[23:8] == 16'hFFFF
      || $past(bus_req.addr[23:8]) == 16'hFFFF) else $error("peri upper");
   a_one_phase: assert property (!(bus_req.rd && bus_req.wr))
      else $error("read and write together");
   a_unit_ends: assert property (write_end
      |=> !bus_req.rd && !bus_req.wr) else $error("more than one unit");
   a_err_aborts: assert property (bus_req.rd && bus_rsp.done && bus_rsp.err
      |=> !bus_req.wr) else $error("write after bus error");
   a_needs_req: assert property ($rose(bus_req.rd)
      |-> $past(|req_in)) else $error("transfer without request");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("late write response");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("late read data");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
endmodule

bind dirc_channel dirc_monitor mon
(
   .clk(clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .req_in(req_in), .bus_req(bus_req),
   .bus_rsp(bus_rsp)
);

// ### dirc_bus_model.sv
// behavioural on-chip bus; reads return data made from the address, writes are only logged
`timescale 1ns/1ns
module dirc_bus_model
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // bus from the channel
   input wire dirc_pkg::dirc_bus_req_type bus_req,
   output dirc_pkg::dirc_bus_rsp_type bus_rsp,
   // stall and fault control
   input wire logic [1:0] wait_cycles,
   input wire logic fail_next,
   // log of the last unit moved
   output logic [23:0] rd_addr,
   output logic [23:0] wr_addr,
   output logic [15:0] wr_data,
   output int wr_count
);
   import dirc_pkg::*;
   logic [1:0] stall;
   wire busy = (bus_req.rd || bus_req.wr) && !bus_rsp.done;
   wire ready = busy && stall == wait_cycles;
   // read data follows the address so it can be predicted; between
   // answers the data lines toggle so stale data is never mistaken
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         bus_rsp <= '0;
         stall <= 2'h0;
         rd_addr <= 24'h00_0000;
         wr_addr <= 24'h00_0000;
         wr_data <= 16'h0000;
         wr_count <= 0;
      end
      else
      begin
         stall <= (ready || !busy) ? 2'h0 : stall + 2'h1;
         bus_rsp.done <= ready;
         bus_rsp.err <= ready && fail_next;
         bus_rsp.rdata <= ready ? bus_req.addr[15:0] ^ 16'hA5C3
            : ~bus_rsp.rdata;
         if (ready && bus_req.rd)
            rd_addr <= bus_req.addr;
         if (ready && bus_req.wr && !fail_next)
         begin
            wr_addr <= bus_req.addr;
            wr_data <= bus_req.wdata;
            wr_count <= wr_count + 1;
         end
      end
endmodule

// ### test_dma_idle_repeat_channel.sv
// self-checking bench for the idle/repeat transfer channel
`timescale 1ns/1ns
module test_dma_idle_repeat_channel;
   import dirc_pkg::*;
   logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, fail, dir, sz;
   logic [7:0] awaddr, araddr, p, n;
   logic [31:0] wdata, d;
   logic [1:0] wt, r;
   logic [23:0] m, per;
   wire awready, wready, bvalid, arready, rvalid, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [23:0] rd_addr, wr_addr;
   wire [15:0] wr_data;
   dirc_req_type req;
   dirc_bus_req_type breq;
   dirc_bus_rsp_type brsp;
   int wr_count, mismatches, samples_checked, cyc, k, s;
   dirc_channel dut
   (
      .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .req_in(req), .bus_req(breq), .bus_rsp(brsp), .irq(irq)
   );
   dirc_bus_model bus
   (
      .clk(clk), .nrst(nrst), .bus_req(breq), .bus_rsp(brsp),
      .wait_cycles(wt), .fail_next(fail), .rd_addr(rd_addr),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_count(wr_count)
   );
   initial
   begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // checks and bus cycles
   // ---------------------------------------------------------------
   task automatic complete_run;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // handshakes are judged at the falling edge, acted on at the next rise
   task automatic axi_w(input logic [7:0] ad, input logic [31:0] dt);
      logic ta, tw, gb;
      ta = 0;
      tw = 0;
      gb = 0;
      @(posedge clk);
      awaddr <= ad;
      wdata <= dt;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!gb)
      begin
         @(negedge clk);
         gb = ta && tw && bvalid;
         r = bresp;
         ta = ta || (awvalid && awready);
         tw = tw || (wvalid && wready);
         @(posedge clk);
         if (ta)
            awvalid <= 0;
         if (tw)
            wvalid <= 0;
      end
      bready <= 0;
   endtask
   task automatic axi_r(input logic [7:0] ad, output logic [31:0] dt,
      output logic [1:0] rs);
      logic ta, gr, rv;
      ta = 0;
      gr = 0;
      rv = 0;
      @(posedge clk);
      araddr <= ad;
      arvalid <= 1;
      // rready comes a cycle after rvalid so that held read data is seen
      while (!gr)
      begin
         @(negedge clk);
         gr = rv && rvalid;
         dt = rdata;
         rs = rresp;
         rv = ta && rvalid;
         ta = ta || (arvalid && arready);
         @(posedge clk);
         if (ta)
            arvalid <= 0;
         if (rv)
            rready <= 1;
      end
      rready <= 0;
   endtask
   task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
      axi_r(ad, d, r);
      check_word(d, e);
   endtask
   task automatic fire(input int sel);
      @(posedge clk);
      req <= 7'h01 << (sel < 4 ? sel + 3 : 6 - sel);
      @(posedge clk);
      req <= 7'h00;
   endtask
   task automatic xfer(input int sel, input logic [23:0] src,
      input logic [23:0] dst);
      int c;
      c = wr_count;
      fire(sel);
      while (wr_count == c)
         @(posedge clk);
      repeat (2) @(posedge clk);
      check_word(rd_addr, src);
      check_word(wr_addr, dst);
      check_word(wr_data, src[15:0] ^ 16'hA5C3);
   endtask
   task automatic no_xfer(input int sel);
      int c;
      c = wr_count;
      fire(sel);
      repeat (10) @(posedge clk);
      check_word(wr_count, c);
   endtask
   task automatic chk_irq(input logic e);
      @(negedge clk);
      check_word(irq, e);
   endtask
   function automatic logic [31:0] ctl(input logic e, rp, dr, z, input int sl);
      return {25'h000_0000, sl[2:0], z, dr, rp, e};
   endfunction
   function automatic logic [23:0] step(input logic [23:0] b,
      input logic dr, z, input int j);
      return dr ? b - 24'(j << z) : b + 24'(j << z);
   endfunction
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         complete_run;
      end
   end
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial
   begin
      {nrst, awvalid, wvalid, bready, arvalid, rready, fail} = 7'h00;
      {awaddr, araddr, wdata, wt, req} = '0;
      {mismatches, samples_checked, cyc} = '0;
      void'($urandom(44));
      repeat (3) @(posedge clk);
      nrst <= 1;
      for (k = 0; k < 7; k++)
         rd_chk(8'(k * 4), 32'h0000_0000);
      axi_r(8'h1C, d, r);
      check_word(r, 32'h0000_0002);
      axi_w(8'h14, 32'h0000_0001);
      check_word(r, 32'h0000_0000);
      axi_w(8'h1C, 32'h0000_0001);
      check_word(r, 32'h0000_0002);
      $display("test registers done");
      for (s = 0; s < 7; s++)
      begin
         m = {8'h12, 16'($urandom)};
         p = 8'($urandom);
         per = {16'hFFFF, p};
         wt <= 2'($urandom);
         axi_w(8'h00, m);
         axi_w(8'h04, p);
         axi_w(8'h08, 32'h0000_0002);
         axi_w(8'h0C, ctl(1, 0, 1'($urandom), 1'($urandom), s));
         for (k = 0; k < 2; k++)
         begin
            if (s == 5)
               xfer(s, per, m);
            else
               xfer(s, m, per);
            rd_chk(8'h08, 32'(1 - k));
         end
         axi_r(8'h0C, d, r);
         check_word(d[0], 0);
         chk_irq(1);
         no_xfer(s);
         axi_w(8'h10, 32'h0000_0001);
         chk_irq(0);
      end
      axi_w(8'h08, 32'h0000_0000);
      axi_w(8'h0C, ctl(1, 0, 0, 1, 6));
      xfer(6, m, per);
      rd_chk(8'h08, 32'h0000_FFFF);
      rd_chk(8'h10, 32'h0000_0000);
      $display("test idle done");
      axi_w(8'h08, 32'h0000_0005);
      fail <= 1;
      no_xfer(6);
      fail <= 0;
      rd_chk(8'h08, 32'h0000_0005);
      rd_chk(8'h10, 32'h0000_0002);
      chk_irq(0);
      axi_w(8'h14, 32'h0000_0003);
      chk_irq(1);
      axi_w(8'h10, 32'h0000_0002);
      chk_irq(0);
      $display("test bus error done");
      m = {8'h34, 16'($urandom)};
      n = 8'($urandom % 3 + 2);
      dir = 1'($urandom);
      sz = 1'($urandom);
      axi_w(8'h00, m);
      axi_w(8'h08, {n, n});
      axi_w(8'h0C, ctl(1, 1, dir, sz, 4));
      for (k = 0; k <= 2 * n; k++)
      begin
         xfer(4, step(m, dir, sz, k % n), per);
         rd_chk(8'h08, {n - 8'((k + 1) % n), n});
         if (k == n)
         begin
            axi_w(8'h0C, ctl(0, 1, dir, sz, 4));
            no_xfer(4);
            axi_w(8'h0C, ctl(1, 1, dir, sz, 4));
         end
      end
      axi_w(8'h08, 32'h0000_FFFF);
      xfer(4, step(m, dir, sz, 1), per);
      rd_chk(8'h08, 32'h0000_FEFF);
      rd_chk(8'h10, 32'h0000_0000);
      chk_irq(0);
      $display("test repeat done");
      complete_run;
   end
endmodule
